/* File: src/pcr_mode_ctrl.sv */
// Mode entry controller with its Wishbone register file; drives the ramp.
// Assumes classic Wishbone single cycles and a ramp engine on the link.
//
// What the ramp scheme asks of this block, the ramp engine and software
// - Start cores at low frequency, then ramp.
// - Software enables caches before ramp-up.
// - Software may init peripherals after ramp.
// - Step lasts step length reference cycles.
// - Software sets differing power level to ramp.
// - Initial divider change is programmed increment.
// - Up ramp starts at programmed start divider.
// - Down ramp ends at programmed end divider.
// - Software rounds relative step down to 0.05.
// - Software treats slope as rate over 1000.
// - Software computes step count, rounded up.
// - Software sets increment to slope*steps*1000.
// - Software sets end divider from slope, steps.
// - Low target frequency normally 16 MHz.
// - Power level differs: mode change ramps.
// - Same-mode change ramps if level altered.
// - Down ramp uses current source settings.
// - Up ramp uses target source settings.
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
module pcr_mode_ctrl
    import pcr_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // Wishbone slave
    input  wire logic          cyc_i,
    input  wire logic          stb_i,
    input  wire logic          we_i,
    input  wire logic [7:0]    adr_i,
    input  wire logic [3:0]    sel_i,
    input  wire logic [31:0]   dat_i,
    output logic [31:0]        dat_o,
    output logic               ack_o,
    // Link to the ramp engine
    pcr_ramp_if.ctrl           rp,
    // System outputs
    output logic               cores_en_o,
    output logic [1:0]         sys_src_o,
    output logic [1:0]         cur_mode_o
);

    typedef enum logic [2:0] {
        PCR_C_IDLE, PCR_C_DOWN, PCR_C_DWAIT, PCR_C_UP, PCR_C_UWAIT
    } pcr_ctl_t;

    pcr_ctl_t          state_q;
    logic              ack_q;
    logic [31:0]       dat_q;
    logic [DW-1:0]     step_q;
    logic [MCFG_W-1:0] mcfg_q [NMODE];
    logic [31:0]       divc_q [NSRC];
    logic [DW-1:0]     divs_q [NSRC];
    logic [DW-1:0]     dive_q [NSRC];
    logic [1:0]        mode_q;
    logic [1:0]        tgt_q;
    logic [1:0]        src_q;
    logic [LVL_W-1:0]  lvl_q;
    logic              cores_q;

    function automatic logic [31:0] pcr_merge(logic [31:0] old_v,
                                              logic [31:0] new_v,
                                              logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++)
            if (be[b])
                r[8*b +: 8] = new_v[8*b +: 8];
        return r;
    endfunction

    // -------------------------------------------------------------------
    // Bus decode
    // -------------------------------------------------------------------
    wire logic        req_w    = cyc_i && stb_i && !ack_q;
    wire logic        wr_w     = req_w && we_i;
    wire logic [3:0]  grp_w    = adr_i[7:4];
    wire logic [1:0]  idx_w    = adr_i[3:2];
    wire logic        mctl_w   = wr_w && (adr_i == OFS_MCTL) && sel_i[0];
    wire logic        step_wr  = wr_w && (adr_i == OFS_STEP);
    wire logic        mode_wr  = wr_w && (grp_w == GRP_MODE);
    wire logic        divc_wr  = wr_w && (grp_w == GRP_DIVC);
    wire logic        divs_wr  = wr_w && (grp_w == GRP_DIVS);
    wire logic        dive_wr  = wr_w && (grp_w == GRP_DIVE);
    wire logic [1:0]  new_tgt  = dat_i[1:0];
    wire logic [MCFG_W-1:0] new_cfg = mcfg_q[new_tgt];
    wire logic [MCFG_W-1:0] tgt_cfg = mcfg_q[tgt_q];
    wire logic [1:0]  tgt_src  = tgt_cfg[SRC_LSB +: 2];
    // A differing power level turns the ramp on.
    // Level is compared against the level latched at entry, so a
    // same-mode change still ramps after software edits the level.
    wire logic        lvl_diff = new_cfg[LVL_LSB +: LVL_W] != lvl_q;
    // Software must set differing levels; otherwise no ramp.
    wire logic        go_w     = mctl_w && (state_q == PCR_C_IDLE);

    wire logic [31:0] stat_w   = {rp.sys_div, 10'h000, src_q, cores_q,
                                  (state_q != PCR_C_IDLE), mode_q};
    wire logic [31:0] mcfg_rd  = {25'h000_0000, mcfg_q[idx_w]};
    wire logic [31:0] divs_rd  = {16'h0000, divs_q[idx_w]};
    wire logic [31:0] dive_rd  = {16'h0000, dive_q[idx_w]};
    wire logic [31:0] step_rd  = {16'h0000, step_q};
    wire logic [31:0] mctl_rd  = {30'h0000_0000, tgt_q};
    wire logic [31:0] rdat_w   = (adr_i == OFS_MCTL) ? mctl_rd
                               : (adr_i == OFS_STAT) ? stat_w
                               : (adr_i == OFS_STEP) ? step_rd
                               : (grp_w == GRP_MODE) ? mcfg_rd
                               : (grp_w == GRP_DIVC) ? divc_q[idx_w]
                               : (grp_w == GRP_DIVS) ? divs_rd
                               : (grp_w == GRP_DIVE) ? dive_rd
                               : WORD_RST;
    wire logic [31:0] step_mg  = pcr_merge(step_rd, dat_i, sel_i);
    wire logic [31:0] mcfg_mg  = pcr_merge(mcfg_rd, dat_i, sel_i);
    wire logic [31:0] divs_mg  = pcr_merge(divs_rd, dat_i, sel_i);
    wire logic [31:0] dive_mg  = pcr_merge(dive_rd, dat_i, sel_i);

    // -------------------------------------------------------------------
    // Bus answer
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            dat_q <= WORD_RST;
        end
        else
        begin
            ack_q <= req_w;
            dat_q <= req_w ? rdat_w : dat_q;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // -------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------
    // Settings are software's to compute
    // all shape the values written here; hardware takes them as is.
    always_ff @(posedge clk_i) begin
        if (rst_i)
        begin
            step_q <= STEP_RST;
            for (int i = 0; i < NMODE; i++)
                mcfg_q[i] <= MCFG_RST;
            for (int i = 0; i < NSRC; i++)
            begin
                divc_q[i] <= WORD_RST;
                divs_q[i] <= DIV_UNITY;
                dive_q[i] <= DIV_UNITY;
            end
        end
        else
        begin
            if (step_wr)
                step_q <= step_mg[DW-1:0];
            if (mode_wr)
                mcfg_q[idx_w] <= mcfg_mg[MCFG_W-1:0];
            if (divc_wr)
                divc_q[idx_w] <= pcr_merge(divc_q[idx_w], dat_i, sel_i);
            if (divs_wr)
                divs_q[idx_w] <= divs_mg[DW-1:0];
            if (dive_wr)
                dive_q[idx_w] <= dive_mg[DW-1:0];
        end
    end

    // -------------------------------------------------------------------
    // Mode sequencer
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i)
        begin
            state_q <= PCR_C_IDLE;
            mode_q  <= '0;
            tgt_q   <= '0;
            src_q   <= '0;
            lvl_q   <= '0;
            cores_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                PCR_C_IDLE:
                    if (go_w)
                    begin
                        tgt_q <= new_tgt;
                        if (lvl_diff)
                            state_q <= PCR_C_DOWN;
                        else
                        begin
                            mode_q  <= new_tgt;
                            src_q   <= new_cfg[SRC_LSB +: 2];
                            cores_q <= new_cfg[CORE_BIT];
                        end
                    end
                PCR_C_DOWN:
                    state_q <= PCR_C_DWAIT;
                PCR_C_DWAIT:
                    if (rp.ramp_done)
                    begin
                        // Cores come up while the clock is slow.
                        src_q   <= tgt_src;
                        cores_q <= tgt_cfg[CORE_BIT];
                        state_q <= PCR_C_UP;
                    end
                PCR_C_UP:
                    state_q <= PCR_C_UWAIT;
                PCR_C_UWAIT:
                    // Mode entry ends on the engine's completion.
                    if (rp.ramp_done)
                    begin
                        mode_q  <= tgt_q;
                        lvl_q   <= tgt_cfg[LVL_LSB +: LVL_W];
                        state_q <= PCR_C_IDLE;
                    end
                default:
                    state_q <= PCR_C_IDLE;
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Link drive
    // -------------------------------------------------------------------
    // Down ramp names the current source, up ramp the target.
    // Caches and peripherals are software's, around the ramp.
    assign rp.ramp_req          = (state_q == PCR_C_DOWN) || (state_q == PCR_C_UP);
    assign rp.ramp_up           = (state_q == PCR_C_UP);
    assign rp.ramp_src          = src_q;
    assign rp.step_length_field = step_q;
    for (genvar s = 0; s < NSRC; s++)
    begin : g_src
        assign rp.div_init[s]              = divc_q[s][DW-1:0];
        assign rp.div_rate[s]              = divc_q[s][RATE_LSB +: DW];
        assign rp.ramp_up_start_divider[s] = divs_q[s];
        assign rp.ramp_down_end_divider[s] = dive_q[s];
    end

    assign cores_en_o = cores_q;
    assign sys_src_o  = src_q;
    assign cur_mode_o = mode_q;

endmodule // pcr_mode_ctrl

/* File: src/pcr_pkg.sv */
// Constants, register map and field positions shared by the clock ramp engine and
// the mode entry controller.
// Assumes a single 10 MHz clock domain for both ends.
package pcr_pkg;

    // -------------------------------------------------------------------
    // Sizes
    // -------------------------------------------------------------------
    localparam int NMODE = 4;
    localparam int NSRC  = 4;
    localparam int DW    = 16;

    // Divide-by-one, in thousandths of the divider, minus one.
    localparam logic [DW-1:0] DIV_UNITY = 16'h03E7;
    localparam logic [DW-1:0] DIV_ONE   = 16'h0001;

    // -------------------------------------------------------------------
    // Register map (byte addresses)
    // -------------------------------------------------------------------
    localparam logic [7:0] OFS_MCTL = 8'h00;
    localparam logic [7:0] OFS_STAT = 8'h04;
    localparam logic [7:0] OFS_STEP = 8'h08;
    localparam logic [3:0] GRP_MODE = 4'h1;
    localparam logic [3:0] GRP_DIVC = 4'h2;
    localparam logic [3:0] GRP_DIVS = 4'h3;
    localparam logic [3:0] GRP_DIVE = 4'h4;

    // -------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------
    localparam int LVL_LSB  = 0;
    localparam int LVL_W    = 4;
    localparam int SRC_LSB  = 4;
    localparam int CORE_BIT = 6;
    localparam int MCFG_W   = 7;
    localparam int RATE_LSB = 16;
    localparam int ST_BUSY  = 2;
    localparam int ST_CORE  = 3;
    localparam int ST_SRC   = 4;
    localparam int ST_DIV   = 16;

    // -------------------------------------------------------------------
    // Reset values
    // -------------------------------------------------------------------
    localparam logic [DW-1:0]     STEP_RST = 16'h0010;
    localparam logic [MCFG_W-1:0] MCFG_RST = 7'h00;
    localparam logic [31:0]       WORD_RST = 32'h0000_0000;

endpackage

/* File: src/pcr_ramp_if.sv */
// Link between the mode entry controller and the clock ramp engine.
// Assumes both ends run on the same clock; no clocking block is used.
`timescale 1ns/100ps
interface pcr_ramp_if;
    import pcr_pkg::*;
    logic                ramp_req;
    logic                ramp_up;
    logic [1:0]          ramp_src;
    logic [DW-1:0]       step_length_field;
    logic [DW-1:0]       div_init [NSRC];
    logic [DW-1:0]       div_rate [NSRC];
    logic [DW-1:0]       ramp_up_start_divider [NSRC];
    logic [DW-1:0]       ramp_down_end_divider [NSRC];
    logic                ramp_busy;
    logic                ramp_done;
    logic [DW-1:0]       sys_div;

    modport engine (
        input  ramp_req, ramp_up, ramp_src, step_length_field, div_init,
               div_rate, ramp_up_start_divider, ramp_down_end_divider,
        output ramp_busy, ramp_done, sys_div
    );
    modport ctrl (
        output ramp_req, ramp_up, ramp_src, step_length_field, div_init,
               div_rate, ramp_up_start_divider, ramp_down_end_divider,
        input  ramp_busy, ramp_done, sys_div
    );
endinterface

/* File: src/pcr_ramp_engine.sv */
// Clock ramp engine of the clock generation unit: steps the system divider.
// Assumes ref_tick_i pulses once per 16 MHz reference cycle, synchronous.
`timescale 1ns/100ps
module pcr_ramp_engine
    import pcr_pkg::*;
(
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // Reference tick
    input  wire logic          ref_tick_i,
    // Link to the mode entry controller
    pcr_ramp_if.engine         rp,
    // Divider to the clock tree
    output logic [DW-1:0]      sys_div_o
);

    typedef enum logic {PCR_E_IDLE, PCR_E_RUN} pcr_eng_t;

    pcr_eng_t      state_q;
    logic [DW-1:0] div_q;
    logic [DW-1:0] inc_q;
    logic [DW-1:0] cnt_q;
    logic [1:0]    src_q;
    logic          up_q;
    logic          done_q;

    // -------------------------------------------------------------------
    // Step decode
    // -------------------------------------------------------------------
    // Down ramps index by current source, up by target source.
    wire logic [DW-1:0] rate_w   = rp.div_rate[src_q];
    wire logic [DW-1:0] end_w    = rp.ramp_down_end_divider[src_q];
    wire logic [DW-1:0] floor_w  = (rate_w == '0) ? DIV_ONE : rate_w;
    wire logic [DW-1:0] ld_inc_w = (rp.div_init[rp.ramp_src] == '0) ? DIV_ONE
                                 : rp.div_init[rp.ramp_src];
    wire logic [DW-1:0] len_w    = (rp.step_length_field == '0) ? DIV_ONE
                                 : rp.step_length_field;
    // One step lasts step_length_field reference cycles.
    wire logic          step_w   = (state_q == PCR_E_RUN) && ref_tick_i
                                 && (cnt_q >= len_w - DIV_ONE);
    wire logic [DW:0]   sum_w    = {1'b0, div_q} + {1'b0, inc_q};
    wire logic [DW:0]   lim_w    = {1'b0, DIV_UNITY} + {1'b0, inc_q};
    // Down ramp stops at the end divider.
    wire logic          dn_last  = sum_w >= {1'b0, end_w};
    wire logic          up_last  = {1'b0, div_q} <= lim_w;
    wire logic          last_w   = up_q ? up_last : dn_last;
    // A rate that does not divide the increment must not undershoot the floor.
    wire logic          dec_ok   = (inc_q > floor_w) && (inc_q - floor_w >= rate_w);
    wire logic [DW-1:0] inc_nx   = dec_ok ? inc_q - rate_w : floor_w;

    // -------------------------------------------------------------------
    // Sequencer
    // -------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i)
        begin
            state_q <= PCR_E_IDLE;
            div_q   <= DIV_UNITY;
            inc_q   <= DIV_ONE;
            cnt_q   <= '0;
            src_q   <= '0;
            up_q    <= 1'b0;
            done_q  <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            unique case (state_q)
                PCR_E_IDLE:
                    if (rp.ramp_req)
                    begin
                        state_q <= PCR_E_RUN;
                        src_q   <= rp.ramp_src;
                        up_q    <= rp.ramp_up;
                        cnt_q   <= '0;
                        // First change is the programmed increment.
                        inc_q   <= ld_inc_w;
                        // Up ramp begins at the start divider.
                        div_q   <= rp.ramp_up ? rp.ramp_up_start_divider[rp.ramp_src]
                                              : DIV_UNITY;
                    end
                PCR_E_RUN:
                    if (step_w)
                    begin
                        cnt_q <= '0;
                        inc_q <= inc_nx;
                        if (last_w)
                        begin
                            state_q <= PCR_E_IDLE;
                            done_q  <= 1'b1;
                            div_q   <= up_q ? DIV_UNITY : end_w;
                        end
                        else
                            div_q <= up_q ? div_q - inc_q : sum_w[DW-1:0];
                    end
                    else if (ref_tick_i)
                        cnt_q <= cnt_q + DIV_ONE;
            endcase
        end
    end

    assign rp.ramp_busy = (state_q == PCR_E_RUN);
    assign rp.ramp_done = done_q;
    assign rp.sys_div   = div_q;
    assign sys_div_o    = div_q;

endmodule // pcr_ramp_engine

/* File: dv/pcr_monitor.sv */
// Checker for the link between the mode controller and the ramp engine.
// Assumes one clock domain and the link signals wired in as plain inputs.
`timescale 1ns/100ps
module pcr_monitor
    import pcr_pkg::*;
(
    // Clock, reset, reference tick and core enable
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    input  wire logic          ref_tick_i,
    input  wire logic          cores_en_o,
    // Link signals
    input  wire logic          ramp_req,
    input  wire logic          ramp_up,
    input  wire logic [1:0]    ramp_src,
    input  wire logic [DW-1:0] step_length_field,
    input  wire logic [DW-1:0] div_init [NSRC],
    input  wire logic [DW-1:0] ramp_up_start_divider [NSRC],
    input  wire logic [DW-1:0] ramp_down_end_divider [NSRC],
    input  wire logic          ramp_busy,
    input  wire logic          ramp_done,
    input  wire logic [DW-1:0] sys_div
);
    // ---------------------------------------------------------------
    // Helper logic
    // ---------------------------------------------------------------
    logic          up_q;
    logic [DW-1:0] tick_q;
    // A zero step length behaves as one tick per step.
    wire  [DW-1:0] last_w  = (step_length_field == '0) ? '0 : step_length_field - 1'b1;
    wire  [DW-1:0] first_w = DIV_UNITY + div_init[ramp_src];
    wire  [DW-1:0] end_w   = ramp_down_end_divider[ramp_src];

    always_ff @(posedge clk_i)
    begin
        if (rst_i || ramp_req || (ref_tick_i && tick_q == last_w))
            tick_q <= '0;
        else if (ref_tick_i && ramp_busy)
            tick_q <= tick_q + 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            up_q <= 1'b0;
        else if (ramp_req)
            up_q <= ramp_up;
    end

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_up_req;
        ramp_req && ramp_up;
    endsequence
    sequence s_down_end;
        ramp_done && !up_q;
    endsequence

    a_req_pulse: assert property (ramp_req |=> !ramp_req)
        else $error("ramp request longer than one cycle");
    a_req_when_idle: assert property (ramp_req |-> !ramp_busy)
        else $error("ramp request while engine busy");
    a_busy_from_req: assert property ($rose(ramp_busy) |-> $past(ramp_req))
        else $error("engine busy without request");
    a_done_pulse: assert property (ramp_done |=> !ramp_done)
        else $error("done longer than one cycle");
    a_step_ref_ticks: assert property ($changed(sys_div) && $past(ramp_busy)
        && !$past(ramp_req) |-> $past(ref_tick_i) && $past(tick_q) == $past(last_w))
        else $error("divider step not on step length boundary");
    a_up_start_div: assert property (s_up_req
        |=> sys_div == ramp_up_start_divider[ramp_src])
        else $error("up ramp did not start at start divider");
    a_down_end_div: assert property (s_down_end |-> sys_div == end_w)
        else $error("down ramp did not end at end divider");
    a_up_end_unity: assert property (ramp_done && up_q |-> sys_div == DIV_UNITY)
        else $error("up ramp did not end at unity divider");
    a_first_incr: assert property ($changed(sys_div) && $past(sys_div) == DIV_UNITY
        && !up_q |-> sys_div == ((first_w >= end_w) ? end_w : first_w))
        else $error("first down step not the initial increment");
    a_up_follows: assert property (s_down_end |-> ##[1:4] s_up_req)
        else $error("no up ramp after down ramp");
    a_cores_at_low: assert property ($rose(cores_en_o) && $past(ramp_done)
        |-> sys_div == $past(end_w))
        else $error("cores enabled away from low frequency");
    a_done_bounded: assert property (ramp_req |-> ##[2:1000] ramp_done)
        else $error("ramp never completed");
endmodule // pcr_monitor

/* File: dv/tb_progressive_clock_ramp.sv */
// Testbench for the mode controller and ramp engine joined by their link.
// Assumes the controller's Wishbone map and a reference tick made here.
`timescale 1ns/100ps
module tb_progressive_clock_ramp
    import pcr_pkg::*;
;
    logic          clk_i      = 1'b0;
    logic          rst_i      = 1'b1;
    logic          ref_tick_i = 1'b0;
    logic          cyc_i      = 1'b0;
    logic          stb_i      = 1'b0;
    logic          we_i       = 1'b0;
    logic [7:0]    adr_i      = '0;
    logic [3:0]    sel_i      = '0;
    logic [31:0]   dat_i      = '0;
    logic [31:0]   dat_o;
    logic          ack_o;
    logic          cores_en_o;
    logic [1:0]    sys_src_o;
    logic [1:0]    cur_mode_o;
    logic [DW-1:0] sys_div_o;
    logic [1:0]    tick_cnt   = '0;
    logic          up_b       = 1'b0;
    logic          req_b      = 1'b0;
    logic [DW-1:0] up_start;
    logic [DW-1:0] dn_end;
    logic [31:0]   rd;
    logic [31:0]   dc;
    int            num_errors = 0;
    int            checked    = 0;
    int            n_req      = 0;
    logic [7:0]    rst_adr [6] = '{OFS_STEP, 8'h30, 8'h4C, 8'h10, 8'hF0, OFS_STAT};
    logic [31:0]   rst_val [6] = '{32'h0000_0010, 32'h0000_03E7, 32'h0000_03E7,
                                   32'h0000_0000, 32'h0000_0000, 32'h03E7_0000};

    always #50 clk_i = ~clk_i;

    // Three ticks in four cycles, so step counting must skip idle cycles.
    always @(posedge clk_i)
    begin
        tick_cnt   <= tick_cnt + 2'd1;
        ref_tick_i <= (tick_cnt != 2'd3);
    end

    pcr_ramp_if rp_if ();
    pcr_ramp_engine i_pcr_ramp_engine (.clk_i(clk_i), .rst_i(rst_i), .ref_tick_i(ref_tick_i),
        .rp(rp_if.engine), .sys_div_o(sys_div_o));
    pcr_mode_ctrl i_pcr_mode_ctrl (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .rp(rp_if.ctrl), .cores_en_o(cores_en_o), .sys_src_o(sys_src_o),
        .cur_mode_o(cur_mode_o));
    pcr_monitor i_pcr_monitor (.clk_i(clk_i), .rst_i(rst_i), .ref_tick_i(ref_tick_i),
        .cores_en_o(cores_en_o), .ramp_req(rp_if.ramp_req), .ramp_up(rp_if.ramp_up),
        .ramp_src(rp_if.ramp_src), .step_length_field(rp_if.step_length_field),
        .div_init(rp_if.div_init), .ramp_up_start_divider(rp_if.ramp_up_start_divider),
        .ramp_down_end_divider(rp_if.ramp_down_end_divider), .ramp_busy(rp_if.ramp_busy),
        .ramp_done(rp_if.ramp_done), .sys_div(rp_if.sys_div));

    // Records the ramps seen on the link.
    always @(posedge clk_i)
    begin
        if (req_b && up_b)
            up_start = rp_if.sys_div;
        if (rp_if.ramp_done && !up_b)
            dn_end = rp_if.sys_div;
        if (rp_if.ramp_req)
        begin
            up_b = rp_if.ramp_up;
            n_req++;
        end
        req_b = rp_if.ramp_req;
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk16(input logic [DW-1:0] got, input logic [DW-1:0] exp);
        checked++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= 4'hF;
        dat_i <= d;
        do
        begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        if (n >= 20)
            num_errors++;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i  <= 1'b0;
    endtask

    // A second mode write during the ramp must be ignored.
    task automatic go(input logic [1:0] m, input logic [1:0] s, input logic c, input int nr,
                      input logic extra);
        int r0;
        int n;
        r0 = n_req;
        n  = 0;
        wb(OFS_MCTL, 1'b1, {30'h0, m});
        if (extra)
            wb(OFS_MCTL, 1'b1, 32'h0000_0000);
        // Software waits out the ramp before further setup.
        do
        begin
            wb(OFS_STAT, 1'b0, '0);
            n++;
        end while (rd[ST_BUSY] !== 1'b0 && n < 500);
        if (n >= 500)
            num_errors++;
        chk32(rd, {DIV_UNITY, 10'h000, s, c, 1'b0, m});
        chk32({sys_div_o, 10'h000, sys_src_o, cores_en_o, 1'b0, cur_mode_o},
              {DIV_UNITY, 10'h000, s, c, 1'b0, m});
        chk32(32'(n_req - r0), 32'(nr));
    endtask

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #2_000_000;
        num_errors++;
        give_verdict();
    end

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial
    begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(8'hF0, 1'b1, 32'hFFFF_FFFF);
        wb(OFS_STAT, 1'b1, 32'hFFFF_FFFF);
        for (int i = 0; i < 6; i++)
        begin
            wb(rst_adr[i], 1'b0, '0);
            chk32(rd, rst_val[i]);
        end
        wb(OFS_STEP, 1'b1, 32'h0000_0002);
        for (int s = 0; s < NSRC; s++)
        begin
            dc = {16'h0032, 16'(200 + 16 * s)};
            wb(8'h20 + 8'(4 * s), 1'b1, dc);
            wb(8'h30 + 8'(4 * s), 1'b1, {16'h0000, 16'h0700 + 16'(s)});
            wb(8'h40 + 8'(4 * s), 1'b1, {16'h0000, 16'h0600 + 16'(s)});
            wb(8'h20 + 8'(4 * s), 1'b0, '0);
            chk32(rd, dc);
        end
        wb(8'h14, 1'b1, 32'h0000_0061);
        wb(8'h18, 1'b1, 32'h0000_0051);
        wb(8'h1C, 1'b1, 32'h0000_0033);
        go(2'd1, 2'd2, 1'b1, 2, 1'b0);
        chk16(dn_end, 16'h0600);
        chk16(up_start, 16'h0702);
        go(2'd2, 2'd1, 1'b1, 0, 1'b0);
        go(2'd2, 2'd1, 1'b1, 0, 1'b0);
        wb(8'h18, 1'b1, 32'h0000_0052);
        go(2'd2, 2'd1, 1'b1, 2, 1'b0);
        chk16(dn_end, 16'h0601);
        chk16(up_start, 16'h0701);
        go(2'd3, 2'd3, 1'b0, 2, 1'b1);
        chk16(up_start, 16'h0703);
        go(2'd0, 2'd0, 1'b0, 2, 1'b0);
        chk16(dn_end, 16'h0603);
        chk16(up_start, 16'h0700);
        give_verdict();
    end
endmodule // tb_progressive_clock_ramp
